// *** core/acdsc_pkg.sv ***
// Constants and types of the accessory detect switch controller
package acdsc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_INT1 = 8'h03;
    localparam logic [7:0] ADDR_ADC = 8'h07;
    localparam logic [7:0] ADDR_DEV1 = 8'h09;
    localparam logic [7:0] ADDR_DEV2 = 8'h0a;
    localparam logic [7:0] ADDR_MANSW = 8'h13;
    localparam logic [7:0] ADDR_RESET = 8'h1b;
    localparam logic [7:0] ADDR_GPO = 8'h1c;
    localparam logic [7:0] ADDR_LDO1 = 8'h1d;
    localparam logic [7:0] ADDR_LDO2 = 8'h1e;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_MASK_BIT = 0;
    localparam int CTRL_AUTO_BIT = 2;
    localparam logic [7:0] CTRL_RST = 8'h05;
    localparam int INT1_ATTACH_BIT = 0;
    localparam int INT1_DETACH_BIT = 1;
    localparam int RESET_BIT = 0;
    localparam int MSW_JIG_BIT = 0;
    localparam int MSW_DP_LSB = 2;
    localparam int MSW_DM_LSB = 5;
    localparam int GPO_LVL1_BIT = 0;
    localparam int GPO_LVL2_BIT = 1;
    localparam int GPO_OD1_BIT = 2;
    localparam int GPO_OD2_BIT = 3;
    localparam int GPO_REFEN_BIT = 4;
    localparam int LDO_EN_BIT = 7;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam int DEV1_SDP_BIT = 0;
    localparam int DEV1_CDP_BIT = 1;
    localparam int DEV1_DCP_BIT = 2;
    localparam int DEV1_TA_BIT = 3;
    localparam int DEV2_JUSB_OFF_BIT = 0;
    localparam int DEV2_JUSB_ON_BIT = 1;
    localparam int DEV2_JUART_OFF_BIT = 2;
    localparam int DEV2_JUART_ON_BIT = 3;
    localparam int DEV2_UNKNOWN_BIT = 4;

    // Switch path codes for one data line
    localparam logic [2:0] PATH_OPEN = 3'h0;
    localparam logic [2:0] PATH_HOST_A = 3'h1;
    localparam logic [2:0] PATH_HOST_B = 3'h2;

    // ************************************************************
    // Identification codes and regulator steps
    // ************************************************************
    localparam logic [4:0] ID_CHARGER = 5'h17;
    localparam logic [4:0] ID_JIG_USB_OFF = 5'h18;
    localparam logic [4:0] ID_JIG_USB_ON = 5'h19;
    localparam logic [4:0] ID_JIG_UART_OFF = 5'h1c;
    localparam logic [4:0] ID_JIG_UART_ON = 5'h1d;
    localparam logic [4:0] ID_OPEN = 5'h1f;
    localparam int LDO_MIN_MV = 1800;
    localparam int LDO_MAX_MV = 3600;
    localparam int LDO_STEP_MV = 100;
    localparam logic [4:0] LDO_CODE_MAX = 5'((LDO_MAX_MV - LDO_MIN_MV) / LDO_STEP_MV);

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 40;
    localparam int DEB_CYC = 16;
    localparam int T_PRIM_DET_US = 40000;
    localparam int PRIM_DET_CYC = T_PRIM_DET_US * CLK_MHZ;
    localparam int BC_CNT_W = 21;

    // ************************************************************
    // Accessory classes
    // ************************************************************
    typedef enum logic [3:0] {
        ACC_NONE = 4'h0,
        ACC_SDP = 4'h1,
        ACC_CDP = 4'h2,
        ACC_DCP = 4'h3,
        ACC_CHARGER = 4'h4,
        ACC_JIG_USB_OFF = 4'h5,
        ACC_JIG_USB_ON = 4'h6,
        ACC_JIG_UART_OFF = 4'h7,
        ACC_JIG_UART_ON = 4'h8,
        ACC_UNKNOWN = 4'h9
    } acdsc_class_e;

endpackage

// *** core/acdsc_cls_if.sv ***
// Interface carrying detection results from the classifier to the controller
`timescale 1ns/1ps
interface acdsc_cls_if;
    import acdsc_pkg::*;
    logic result;
    acdsc_class_e cls;
    logic [4:0] code;
    modport src (output result, output cls, output code);
    modport dst (input result, input cls, input code);
endinterface

// *** core/acdsc_classify.sv ***
// Accessory classifier: input settling filter, charger port detection, class decode
`timescale 1ns/1ps
module acdsc_classify #(
    parameter int PRIM_CYC = acdsc_pkg::PRIM_DET_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sensed connector state
    input wire logic conn_bus_power,
    input wire logic [4:0] id_code,
    input wire logic data_short,
    input wire logic bc_resp,
    // Charger detection source drive
    output logic bc_src_en,
    // Result towards the controller
    acdsc_cls_if.src res
);
    import acdsc_pkg::*;

    typedef enum logic [1:0] {
        CS_FILTER = 2'b01,
        CS_BCDET = 2'b10
    } acdsc_cst_e;

    typedef struct packed {
        acdsc_cst_e st;
        logic [6:0] smp;
        logic [6:0] done;
        logic done_valid;
        logic [4:0] deb_cnt;
        logic [BC_CNT_W-1:0] bc_cnt;
        acdsc_class_e cls;
        logic [4:0] code;
        logic result;
        logic src_en;
    } acdsc_cls_s;

    acdsc_cls_s s_r;
    acdsc_cls_s s_nxt;
    logic [6:0] raw;
    logic changed;
    logic stable;

    // Decode of a settled identification code and bus power state
    function automatic acdsc_class_e decode(input logic [4:0] c, input logic vb,
                                            input logic sh);
        acdsc_class_e r;
        case (c)
            ID_CHARGER: r = vb ? ACC_CHARGER : ACC_NONE; // [R5] [R11]
            ID_JIG_USB_OFF: r = ACC_JIG_USB_OFF; // [R1] [R4]
            ID_JIG_USB_ON: r = ACC_JIG_USB_ON; // [R1] [R4]
            ID_JIG_UART_OFF: r = ACC_JIG_UART_OFF; // [R1] [R3]
            ID_JIG_UART_ON: r = ACC_JIG_UART_ON; // [R1] [R3]
            ID_OPEN: r = !vb ? ACC_NONE : (sh ? ACC_DCP : ACC_SDP); // [R12]
            default: r = ACC_UNKNOWN; // [R6]
        endcase
        return r;
    endfunction

    // Settling filter and detection sequence
    always_comb begin
        raw = {conn_bus_power, data_short, id_code};
        changed = (raw != s_r.smp);
        stable = !changed && (s_r.deb_cnt == 5'(DEB_CYC));
        s_nxt = s_r;
        s_nxt.result = 1'b0;
        s_nxt.smp = raw;
        if (changed) begin
            s_nxt.deb_cnt = 5'h00;
        end else if (s_r.deb_cnt != 5'(DEB_CYC)) begin
            s_nxt.deb_cnt = s_r.deb_cnt + 5'h01;
        end
        case (s_r.st)
            CS_FILTER: begin
                s_nxt.src_en = 1'b0;
                // A new settled code re-evaluates even while attached
                if (stable && (!s_r.done_valid || raw != s_r.done)) begin // [R2]
                    s_nxt.done = raw;
                    s_nxt.done_valid = 1'b1;
                    s_nxt.code = id_code;
                    if (id_code == ID_OPEN && conn_bus_power && !data_short) begin // [R13]
                        s_nxt.st = CS_BCDET;
                        s_nxt.bc_cnt = '0;
                        s_nxt.src_en = 1'b1;
                    end else begin
                        s_nxt.cls = decode(id_code, conn_bus_power, data_short);
                        s_nxt.result = 1'b1;
                    end
                end
            end
            CS_BCDET: begin
                if (changed) begin
                    // Abandon and settle again
                    s_nxt.st = CS_FILTER;
                    s_nxt.src_en = 1'b0;
                    s_nxt.done_valid = 1'b0;
                end else if (s_r.bc_cnt == BC_CNT_W'(PRIM_CYC - 1)) begin
                    s_nxt.cls = bc_resp ? ACC_CDP : ACC_SDP; // [R13]
                    s_nxt.result = 1'b1;
                    s_nxt.st = CS_FILTER;
                    s_nxt.src_en = 1'b0;
                end else begin
                    s_nxt.bc_cnt = s_r.bc_cnt + BC_CNT_W'(1);
                end
            end
            default: begin
                s_nxt.st = CS_FILTER;
                s_nxt.src_en = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: CS_FILTER, cls: ACC_NONE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bc_src_en = s_r.src_en;
    assign res.result = s_r.result;
    assign res.cls = s_r.cls;
    assign res.code = s_r.code;

endmodule

// *** core/acdsc_top.sv ***
// Accessory detect and switch controller: registers, switching, interrupt, outputs
//
// Function
// R1: Factory codes set factory switch paths with no processor action.
// R2: A new factory code while attached reconfigures switches, no detach.
// R3: UART jig routes connector pair to second host pair.
// R4: USB jig routes connector pair to primary host pair.
// R5: Charger codes detect only with valid bus power.
// R6: Resistance between ranges reports an adjacent code.
// R7: A detection result updates status, then asserts the interrupt.
// R8: Interrupt output goes low on a detection change.
// R9: Processor reads event flags before status registers.
// R10: USB and chargers in first type register; factory, unknown in second.
// R11: Bus power with charger code reports travel adapter; data unchecked.
// R12: Bus power, open code, shorted data lines report dedicated charger.
// R13: Bus power, open identification, host lines use charger procedure for CDP/SDP.
// R14: Downstream ports connect data lines to primary host.
// R15: Dedicated charging port keeps host switches open.
// R16: Switches set automatically from detection, or manually.
// R17: Manual mode: switch register sets data switches and jig output.
// R18: Factory switches wait for processor I/O supply.
// R19: Outputs default push-pull; select bit high makes them open-drain.
// R20: Regulator codes span 1.8 V to 3.6 V in 100 mV steps.
// R21: Processor enables reference at least 20 ms before any regulator.
// R22: Interrupt masked until processor clears control mask bit.
// R23: Identification resistance gives a 5-bit code shown with the interrupt.
// R24: Interrupt returns high after flag read with nothing pending.
`timescale 1ns/1ps
module acdsc_top #(
    parameter int PRIM_CYC = acdsc_pkg::PRIM_DET_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sensed connector state
    input wire logic conn_bus_power,
    input wire logic [4:0] conn_ident_code,
    input wire logic conn_data_short,
    input wire logic bc_resp,
    input wire logic proc_io_supply,
    // Register access from the serial slave
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt
    output logic irq_out_n,
    // Data switches
    output logic sw_pos_host_a,
    output logic sw_neg_host_a,
    output logic sw_pos_host_b,
    output logic sw_neg_host_b,
    // Jig output, open drain
    output logic jig_o,
    output logic jig_oe_n,
    // Charger detection source drive
    output logic bc_src_en,
    // General outputs and regulators
    output logic [1:0] gpo_o,
    output logic [1:0] gpo_oe_n,
    output logic ref_en,
    output logic [4:0] ldo1_set,
    output logic [4:0] ldo2_set,
    output logic [1:0] ldo_en
);
    import acdsc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] int1;
        logic [7:0] dev1;
        logic [7:0] dev2;
        logic [7:0] mansw;
        logic [7:0] gpo;
        logic [7:0] ldo1;
        logic [7:0] ldo2;
        logic [4:0] adc;
        acdsc_class_e cls;
        logic [7:0] rdata;
        logic irq_n;
        logic [3:0] sw;
        logic jig_oe_n;
        logic [1:0] gpo_o;
        logic [1:0] gpo_oe_n;
    } acdsc_regs_s;

    localparam acdsc_regs_s REGS_RST = '{
        ctrl: CTRL_RST,
        cls: ACC_NONE,
        irq_n: 1'b1,
        jig_oe_n: 1'b1,
        default: '0
    };

    acdsc_regs_s s_r;
    acdsc_regs_s s_nxt;
    logic rst_meta_r;
    logic rst_sync_r;
    logic [2:0] dp_path;
    logic [2:0] dm_path;
    logic jig_drive;
    logic is_jig;
    logic [7:0] rd_val;

    acdsc_cls_if cls_if ();

    // ************************************************************
    // Reset release
    // ************************************************************
    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ************************************************************
    // Classifier
    // ************************************************************
    acdsc_classify #(
        .PRIM_CYC(PRIM_CYC)
    ) u_classify (
        .clk(clk),
        .rst_n(rst_sync_r),
        .conn_bus_power(conn_bus_power),
        .id_code(conn_ident_code),
        .data_short(conn_data_short),
        .bc_resp(bc_resp),
        .bc_src_en(bc_src_en),
        .res(cls_if.src)
    );

    // Clamp a written regulator code to the top of the voltage span
    function automatic logic [7:0] ldo_clamp(input logic [7:0] w);
        logic [4:0] c;
        c = (w[4:0] > LDO_CODE_MAX) ? LDO_CODE_MAX : w[4:0]; // [R20]
        return {w[LDO_EN_BIT], 2'h0, c};
    endfunction

    // ************************************************************
    // Switch path selection
    // ************************************************************
    // Automatic paths from the current class, or manual paths from the register
    always_comb begin
        is_jig = s_r.cls inside {ACC_JIG_USB_OFF, ACC_JIG_USB_ON, ACC_JIG_UART_OFF,
                                 ACC_JIG_UART_ON};
        dp_path = PATH_OPEN;
        dm_path = PATH_OPEN;
        jig_drive = 1'b0;
        if (s_r.ctrl[CTRL_AUTO_BIT]) begin // [R16]
            case (s_r.cls)
                ACC_SDP, ACC_CDP: begin
                    dp_path = PATH_HOST_A; // [R14]
                    dm_path = PATH_HOST_A;
                end
                ACC_JIG_USB_OFF, ACC_JIG_USB_ON: begin
                    dp_path = proc_io_supply ? PATH_HOST_A : PATH_OPEN; // [R4] [R18]
                    dm_path = proc_io_supply ? PATH_HOST_A : PATH_OPEN;
                end
                ACC_JIG_UART_OFF, ACC_JIG_UART_ON: begin
                    dp_path = proc_io_supply ? PATH_HOST_B : PATH_OPEN; // [R3] [R18]
                    dm_path = proc_io_supply ? PATH_HOST_B : PATH_OPEN;
                end
                default: begin
                    dp_path = PATH_OPEN; // [R15]
                    dm_path = PATH_OPEN;
                end
            endcase
            jig_drive = is_jig && proc_io_supply; // [R1] [R18]
        end else begin
            dp_path = s_r.mansw[MSW_DP_LSB +: 3]; // [R17]
            dm_path = s_r.mansw[MSW_DM_LSB +: 3]; // [R17]
            jig_drive = s_r.mansw[MSW_JIG_BIT]; // [R17]
        end
    end

    // ************************************************************
    // Register read mux
    // ************************************************************
    always_comb begin
        case (reg_addr)
            ADDR_CONTROL: rd_val = s_r.ctrl;
            ADDR_INT1: rd_val = s_r.int1;
            ADDR_ADC: rd_val = {3'h0, s_r.adc}; // [R23]
            ADDR_DEV1: rd_val = s_r.dev1;
            ADDR_DEV2: rd_val = s_r.dev2;
            ADDR_MANSW: rd_val = s_r.mansw;
            ADDR_GPO: rd_val = s_r.gpo;
            ADDR_LDO1: rd_val = s_r.ldo1;
            ADDR_LDO2: rd_val = s_r.ldo2;
            default: rd_val = REG_ZERO;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = reg_rd ? rd_val : s_r.rdata;
        // Reading the flag register clears it; new events below win
        if (reg_rd && reg_addr == ADDR_INT1) begin // [R9] [R24]
            s_nxt.int1 = REG_ZERO;
        end
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CONTROL: s_nxt.ctrl = reg_wdata; // [R22]
                ADDR_MANSW: s_nxt.mansw = reg_wdata; // [R17]
                ADDR_GPO: s_nxt.gpo = {3'h0, reg_wdata[4:0]};
                ADDR_LDO1: s_nxt.ldo1 = ldo_clamp(reg_wdata);
                ADDR_LDO2: s_nxt.ldo2 = ldo_clamp(reg_wdata);
                default: ;
            endcase
        end
        // Detection result: status first, interrupt the cycle after
        if (cls_if.result) begin // [R7]
            s_nxt.cls = cls_if.cls;
            s_nxt.adc = cls_if.code; // [R23]
            s_nxt.dev1 = REG_ZERO;
            s_nxt.dev2 = REG_ZERO;
            case (cls_if.cls)
                ACC_SDP: s_nxt.dev1[DEV1_SDP_BIT] = 1'b1; // [R10]
                ACC_CDP: s_nxt.dev1[DEV1_CDP_BIT] = 1'b1; // [R10]
                ACC_DCP: s_nxt.dev1[DEV1_DCP_BIT] = 1'b1; // [R10]
                ACC_CHARGER: s_nxt.dev1[DEV1_TA_BIT] = 1'b1; // [R10] [R11]
                ACC_JIG_USB_OFF: s_nxt.dev2[DEV2_JUSB_OFF_BIT] = 1'b1; // [R10]
                ACC_JIG_USB_ON: s_nxt.dev2[DEV2_JUSB_ON_BIT] = 1'b1; // [R10]
                ACC_JIG_UART_OFF: s_nxt.dev2[DEV2_JUART_OFF_BIT] = 1'b1; // [R10]
                ACC_JIG_UART_ON: s_nxt.dev2[DEV2_JUART_ON_BIT] = 1'b1; // [R10]
                ACC_UNKNOWN: s_nxt.dev2[DEV2_UNKNOWN_BIT] = 1'b1; // [R10]
                default: ;
            endcase
            if (cls_if.cls != ACC_NONE) begin
                s_nxt.int1[INT1_ATTACH_BIT] = 1'b1;
            end else if (s_r.cls != ACC_NONE) begin
                s_nxt.int1[INT1_DETACH_BIT] = 1'b1;
            end
        end
        // Active-low interrupt from pending flags, held off by the mask
        s_nxt.irq_n = !(!s_r.ctrl[CTRL_MASK_BIT] && (s_r.int1 != REG_ZERO)); // [R8] [R22] [R24]
        // Switch and jig outputs
        s_nxt.sw = {dm_path == PATH_HOST_B, dp_path == PATH_HOST_B,
                    dm_path == PATH_HOST_A, dp_path == PATH_HOST_A};
        s_nxt.jig_oe_n = !jig_drive;
        // General outputs: open-drain mode drives only low
        s_nxt.gpo_o = {s_r.gpo[GPO_LVL2_BIT], s_r.gpo[GPO_LVL1_BIT]};
        s_nxt.gpo_oe_n[0] = s_r.gpo[GPO_OD1_BIT] & s_r.gpo[GPO_LVL1_BIT]; // [R19]
        s_nxt.gpo_oe_n[1] = s_r.gpo[GPO_OD2_BIT] & s_r.gpo[GPO_LVL2_BIT]; // [R19]
        // Software reset restores every register and output except the classifier state and bc_src_en
        if (reg_wr && reg_addr == ADDR_RESET && reg_wdata[RESET_BIT]) begin
            s_nxt = REGS_RST;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r <= REGS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata = s_r.rdata;
    assign irq_out_n = s_r.irq_n;
    assign sw_pos_host_a = s_r.sw[0];
    assign sw_neg_host_a = s_r.sw[1];
    assign sw_pos_host_b = s_r.sw[2];
    assign sw_neg_host_b = s_r.sw[3];
    assign jig_o = 1'b0; // Pulls low only
    assign jig_oe_n = s_r.jig_oe_n;
    assign gpo_o = s_r.gpo_o;
    assign gpo_oe_n = s_r.gpo_oe_n;
    assign ref_en = s_r.gpo[GPO_REFEN_BIT]; // [R21]
    assign ldo1_set = s_r.ldo1[4:0];
    assign ldo2_set = s_r.ldo2[4:0];
    assign ldo_en = {s_r.ldo2[LDO_EN_BIT], s_r.ldo1[LDO_EN_BIT]};

endmodule

// *** test/acdsc_accessory.sv ***
// Model of the cable, charger or factory jig on the connector
`timescale 1ns/1ps
module acdsc_accessory (
    // Commanded accessory
    input wire acdsc_pkg::acdsc_class_e kind,
    input wire logic no_power,
    // Source drive from the controller
    input wire logic bc_src_en,
    // Connector state
    output logic conn_bus_power,
    output logic [4:0] conn_ident_code,
    output logic conn_data_short,
    output logic bc_resp
);
    import acdsc_pkg::*;
    // Only chargers and host ports bring bus power
    assign conn_bus_power = (kind inside {ACC_SDP, ACC_CDP, ACC_DCP, ACC_CHARGER}) && !no_power;
    assign conn_data_short = (kind == ACC_DCP);
    // A charging port answers only while the source is driven
    assign bc_resp = (kind == ACC_CDP) && bc_src_en;
    // Resistance code on the identification pin
    always_comb begin
        case (kind)
            ACC_CHARGER: conn_ident_code = ID_CHARGER;
            ACC_JIG_USB_OFF: conn_ident_code = ID_JIG_USB_OFF;
            ACC_JIG_USB_ON: conn_ident_code = ID_JIG_USB_ON;
            ACC_JIG_UART_OFF: conn_ident_code = ID_JIG_UART_OFF;
            ACC_JIG_UART_ON: conn_ident_code = ID_JIG_UART_ON;
            ACC_UNKNOWN: conn_ident_code = 5'h15;
            default: conn_ident_code = ID_OPEN;
        endcase
    end
endmodule

// *** test/acdsc_top_assertions.sv ***
// Checker of port timing of the accessory detect switch controller
`timescale 1ns/1ps
module acdsc_top_assertions
    import acdsc_pkg::*;
#(
    parameter int PRIM_CYC = PRIM_DET_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Connector and register port
    input wire logic conn_bus_power,
    input wire logic [4:0] conn_ident_code,
    input wire logic conn_data_short,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Outputs
    input wire logic irq_out_n,
    input wire logic sw_pos_host_a,
    input wire logic sw_pos_host_b,
    input wire logic jig_o,
    input wire logic bc_src_en,
    input wire logic [4:0] ldo1_set
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [31:0] bc_cnt_r;
    // Length of the current source drive phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bc_cnt_r <= 32'h0;
        end else begin
            bc_cnt_r <= bc_src_en ? bc_cnt_r + 32'h1 : 32'h0;
        end
    end
    // ********************
    // Assertions
    // ********************
    a_irq_hold: assert property (
        !irq_out_n && !$past(reg_rd) && !reg_wr && !$past(reg_wr) |=> !irq_out_n)
        else $error("irq rose unread");
    a_rdata_hold: assert property (
        !$past(reg_rd) && !$past(reg_wr) |-> $stable(reg_rdata)) else $error("rdata moved");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ldo_range: assert property (ldo1_set <= LDO_CODE_MAX)
        else $error("ldo code high");
    a_pos_one_path: assert property (!(sw_pos_host_a && sw_pos_host_b))
        else $error("two paths closed");
    a_jig_low: assert property (jig_o == 1'b0)
        else $error("jig level not low");
    a_bc_start: assert property ($rose(bc_src_en) |-> $past(conn_bus_power)
        && $past(conn_ident_code) == ID_OPEN && !$past(conn_data_short))
        else $error("bad source start");
    a_bc_bound: assert property (bc_src_en |-> bc_cnt_r < 32'(PRIM_CYC))
        else $error("source phase too long");
    a_bc_length: assert property ($fell(bc_src_en) |-> $past(bc_cnt_r) == 32'(PRIM_CYC - 1))
        else $error("source phase too short");
    c_irq_low: cover property ($fell(irq_out_n));
    c_bc_phase: cover property ($fell(bc_src_en));
    c_host_b: cover property ($rose(sw_pos_host_b));
endmodule
bind acdsc_top acdsc_top_assertions #(.PRIM_CYC(PRIM_CYC)) u_acdsc_chk (.clk, .resetn,
    .conn_bus_power, .conn_ident_code, .conn_data_short, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .irq_out_n, .sw_pos_host_a, .sw_pos_host_b, .jig_o, .bc_src_en, .ldo1_set);

// *** test/acdsc_top_test.sv ***
// Self-checking bench of the accessory detect switch controller
`timescale 1ns/1ps
module acdsc_top_test;
    import acdsc_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, proc_io_supply = 1'b0, no_power = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    acdsc_class_e kind = ACC_NONE;
    logic conn_bus_power, conn_data_short, bc_resp, bc_src_en, irq_out_n, jig_oe_n, ref_en;
    logic sw_pa, sw_na, sw_pb, sw_nb;
    logic [4:0] conn_ident_code, ldo1_set, ldo2_set;
    logic [7:0] reg_rdata;
    logic [1:0] gpo_o, gpo_oe_n, ldo_en;
    // Jig and switch pins
    wire logic [7:0] swj = {3'h0, jig_oe_n, sw_pa, sw_na, sw_pb, sw_nb};
    int miscompares = 0;
    int samples_checked = 0;
    acdsc_class_e kinds[13] = '{ACC_JIG_USB_OFF, ACC_JIG_UART_OFF, ACC_JIG_UART_ON, ACC_NONE,
        ACC_CHARGER, ACC_NONE, ACC_DCP, ACC_NONE, ACC_CDP, ACC_NONE, ACC_SDP, ACC_NONE, ACC_UNKNOWN};
    logic [7:0] exps[13] = '{8'h01, 8'h04, 8'h08, 0, 8'h08, 0, 8'h04, 0, 8'h02, 0, 8'h01, 0, 8'h10};
    logic [7:0] sws[13] = '{8'h0c, 8'h03, 8'h03, 0, 8'hff, 0, 0, 0, 8'h0c, 0, 8'h0c, 0, 8'hff};

    // Free-running clock
    always #12.5 clk = ~clk;

    acdsc_accessory i_acc (.kind, .no_power, .bc_src_en, .conn_bus_power, .conn_ident_code,
        .conn_data_short, .bc_resp);
    acdsc_top #(.PRIM_CYC(8)) i_dut (.clk, .resetn, .conn_bus_power, .conn_ident_code,
        .conn_data_short, .bc_resp, .proc_io_supply, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .irq_out_n, .sw_pos_host_a(sw_pa), .sw_neg_host_a(sw_na),
        .sw_pos_host_b(sw_pb), .sw_neg_host_b(sw_nb), .jig_o(), .jig_oe_n, .bc_src_en,
        .gpo_o, .gpo_oe_n, .ref_en, .ldo1_set, .ldo2_set, .ldo_en);

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Register accesses: one strobe edge, then an idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, e);
        @(negedge clk);
    endtask
    // Bounded wait for the interrupt
    task automatic wait_irq();
        int n = 0;
        while (irq_out_n !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            miscompares++;
            stop_test();
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        rd(ADDR_CONTROL, CTRL_RST);
        check({gpo_oe_n, 5'h0, irq_out_n}, 8'h01);
        kind = ACC_JIG_USB_ON;
        repeat (40) @(negedge clk);
        check(swj, 8'h10);
        check({7'h0, irq_out_n}, 8'h01);
        wr(ADDR_CONTROL, 8'h04);
        wait_irq();
        proc_io_supply = 1'b1;
        repeat (3) @(negedge clk);
        check(swj, 8'h0c);
        rd(ADDR_INT1, 8'h01);
        rd(ADDR_ADC, {3'h0, ID_JIG_USB_ON});
        rd(ADDR_DEV2, 8'h02);
        for (int i = 0; i < 13; i++) begin
            if (i == 4) begin
                no_power = 1'b1;
                kind = ACC_CHARGER;
                repeat (40) @(negedge clk);
                check({7'h0, irq_out_n}, 8'h01);
            end
            no_power = 1'b0;
            kind = kinds[i];
            wait_irq();
            rd(ADDR_INT1, (kind == ACC_NONE) ? 8'h02 : 8'h01);
            rd((kind >= ACC_JIG_USB_OFF) ? ADDR_DEV2 : ADDR_DEV1, exps[i]);
            if (sws[i] != 8'hff) begin
                check(swj & 8'h0f, sws[i]);
            end
            check({7'h0, irq_out_n}, 8'h01);
        end
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_MANSW, 8'h49);
        check(swj, 8'h03);
        rd(ADDR_MANSW, 8'h49);
        wr(ADDR_MANSW, 8'h24);
        check(swj, 8'h1c);
        wr(ADDR_GPO, 8'h15);
        check({3'h0, gpo_o, ref_en, gpo_oe_n}, 8'h0d);
        wr(ADDR_LDO1, 8'h92);
        wr(ADDR_LDO2, 8'h9f);
        check({1'b0, ldo_en, ldo1_set}, 8'h72);
        check({3'h0, ldo2_set}, 8'h12);
        rd(8'h05, 8'h00);
        wr(ADDR_DEV1, 8'hff);
        rd(ADDR_DEV1, 8'h00);
        stop_test();
    end
endmodule
